// [include/viu_map.svh]
// register offsets, field positions, reset values for the vector interrupt unit
`ifndef VIU_MAP_SVH
`define VIU_MAP_SVH

`define VIU_OFF_RAW         12'h000
`define VIU_OFF_FAST        12'h004
`define VIU_OFF_NORMAL      12'h008
`define VIU_OFF_SRC_EN      12'h00C
`define VIU_OFF_CLASS       12'h010
`define VIU_OFF_VECT        12'h014
`define VIU_OFF_DEFAULT     12'h018
`define VIU_OFF_EVT         12'h01C
`define VIU_OFF_EVT_MASK    12'h020
`define VIU_PAGE_SLOT_CTRL  4'h1
`define VIU_PAGE_SLOT_ADDR  4'h2

`define VIU_SLOT_EN_BIT     5
`define VIU_SLOT_SEL_MSB    4
`define VIU_SLOT_CTRL_W     6
`define VIU_NUM_SLOTS       16
`define VIU_NUM_SRC         32

`define VIU_EVT_FAST        0
`define VIU_EVT_NORMAL      1
`define VIU_EVT_W           2

`define VIU_RST_WORD        32'h0000_0000
`define VIU_RST_CTRL        6'h00
`define VIU_RST_EVT         2'h0

`endif

// [include/viu_pkg.sv]
// shared types of the vector interrupt unit
package viu_pkg;
	typedef logic [31:0] viu_word_t;
	typedef logic [3:0]  viu_slot_idx_t;
	typedef logic [15:0] viu_slot_vec_t;
	typedef logic [3:0]  viu_strb_t;
	typedef logic [11:0] viu_addr_t;
endpackage

// [rtl/viu_slot_arbiter.sv]
// fixed-priority pick among the sixteen vectored slots
`timescale 1ns/1ns
`default_nettype none
module viu_slot_arbiter (
	input  wire viu_pkg::viu_slot_vec_t i_slot_req,
	output var  logic                   o_valid,
	output var  viu_pkg::viu_slot_idx_t o_idx
);
	import viu_pkg::*;

	// slot 0 wins
	// scan from the top so the lowest index is written last and wins
	always_comb begin
		o_valid = 1'b0;
		o_idx   = 4'h0;
		for (int n = 15; n >= 0; n--) begin
			if (i_slot_req[n]) begin
				o_valid = 1'b1;
				o_idx   = 4'(n);
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/viu_ctrl.sv]
// vector interrupt unit: classing, slot arbitration, apb registers
//
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "viu_map.svh"

module viu_ctrl (
	input  wire logic               I_CLK,
	input  wire logic               I_SYS_RST,
	input  wire viu_pkg::viu_word_t I_IRQ_SRC,
	input  wire logic               I_PSEL,
	input  wire logic               I_PENABLE,
	input  wire logic               I_PWRITE,
	input  wire viu_pkg::viu_word_t I_PADDR,
	input  wire viu_pkg::viu_word_t I_PWDATA,
	input  wire viu_pkg::viu_strb_t I_PSTRB,
	output var  viu_pkg::viu_word_t O_PRDATA,
	output var  logic               O_PREADY,
	output var  logic               O_PSLVERR,
	output var  logic               O_FAST_INTERRUPT_REQUEST,
	output var  logic               O_NORMAL_INTERRUPT_REQUEST,
	output var  logic               O_INT
);
	import viu_pkg::*;

	// byte-lane merge for the 32-bit writable registers
	function automatic viu_word_t merge_strb(input viu_word_t old_val, input viu_word_t wdata,
		input viu_strb_t strb);
		viu_word_t res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = wdata[b*8 +: 8];
			end
		end
		return res;
	endfunction

	viu_word_t                      src_enable;
	viu_word_t                      class_fast;
	viu_word_t                      default_addr;
	logic [`VIU_EVT_W-1:0]          evt_mask;
	logic [`VIU_EVT_W-1:0]          evt_status;
	logic [`VIU_EVT_W-1:0]          next_evt;
	logic [`VIU_SLOT_CTRL_W-1:0]    slot_ctrl [`VIU_NUM_SLOTS];
	viu_word_t                      slot_addr [`VIU_NUM_SLOTS];
	viu_word_t                      vect_addr;
	viu_word_t                      req_en;
	viu_word_t                      fast_act;
	viu_word_t                      norm_act;
	viu_slot_vec_t                  slot_req;
	logic                           win_valid;
	viu_slot_idx_t                  win_idx;
	viu_word_t                      next_prdata;
	logic                           next_slverr;
	logic                           access;
	logic                           done_wr;
	logic                           done_rd;
	viu_addr_t                      addr;
	viu_slot_idx_t                  slot_sel;
	logic                           in_slot_ctrl;
	logic                           in_slot_addr;
	logic                           next_fast;
	logic                           next_normal;

	assign addr         = I_PADDR[11:0];
	assign slot_sel     = addr[5:2];
	assign in_slot_ctrl = (addr[11:8] == `VIU_PAGE_SLOT_CTRL) && (addr[7:6] == 2'h0) && (I_PADDR[31:12] == 20'h0);
	assign in_slot_addr = (addr[11:8] == `VIU_PAGE_SLOT_ADDR) && (addr[7:6] == 2'h0) && (I_PADDR[31:12] == 20'h0);
	assign access       = I_PSEL && I_PENABLE;
	// the request is taken only at the edge where pready is seen high
	assign done_wr      = access && O_PREADY && I_PWRITE && !O_PSLVERR;
	assign done_rd      = access && O_PREADY && !I_PWRITE;

	// peripheral lines are levels on this clock, used unsynchronised
	assign req_en = I_IRQ_SRC & src_enable;

	assign fast_act = req_en & class_fast;
	assign norm_act = req_en & ~class_fast;

	always_comb begin
		slot_req = 16'h0000;
		for (int n = 0; n < `VIU_NUM_SLOTS; n++) begin
			slot_req[n] = slot_ctrl[n][`VIU_SLOT_EN_BIT] && norm_act[slot_ctrl[n][`VIU_SLOT_SEL_MSB:0]];
		end
	end

	viu_slot_arbiter u_arb (
		.i_slot_req (slot_req),
		.o_valid    (win_valid),
		.o_idx      (win_idx)
	);

	assign next_fast   = |fast_act;
	// non-vectored sources only reach this merge, never the vector
	assign next_normal = |norm_act;

	// arbitration reevaluated every cycle from current settings
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_FAST_INTERRUPT_REQUEST   <= 1'b0;
			O_NORMAL_INTERRUPT_REQUEST <= 1'b0;
			vect_addr                  <= `VIU_RST_WORD;
		end else begin
			O_FAST_INTERRUPT_REQUEST   <= next_fast;
			O_NORMAL_INTERRUPT_REQUEST <= next_normal;
			vect_addr                  <= win_valid ? slot_addr[win_idx] : default_addr;
		end
	end

	// apb handshake: one wait state on every access
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= `VIU_RST_WORD;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= access && !O_PREADY;
			if (access && !O_PREADY) begin
				O_PRDATA  <= I_PWRITE ? `VIU_RST_WORD : next_prdata;
				O_PSLVERR <= next_slverr;
			end else begin
				O_PRDATA  <= `VIU_RST_WORD;
				O_PSLVERR <= 1'b0;
			end
		end
	end

	// read decode; unmapped addresses answer with an error
	always_comb begin
		next_prdata = `VIU_RST_WORD;
		next_slverr = 1'b0;
		if (in_slot_ctrl) begin
			next_prdata = {26'h0, slot_ctrl[slot_sel]};
		end else if (in_slot_addr) begin
			next_prdata = slot_addr[slot_sel];
		end else if (I_PADDR[31:12] != 20'h0) begin
			next_slverr = 1'b1;
		end else begin
			case (addr)
				`VIU_OFF_RAW: begin
					next_prdata = I_IRQ_SRC;
				end
				`VIU_OFF_FAST: begin
					next_prdata = fast_act;
				end
				`VIU_OFF_NORMAL: begin
					next_prdata = norm_act;
				end
				`VIU_OFF_SRC_EN: begin
					next_prdata = src_enable;
				end
				`VIU_OFF_CLASS: begin
					next_prdata = class_fast;
				end
				`VIU_OFF_VECT: begin
					next_prdata = vect_addr;
				end
				`VIU_OFF_DEFAULT: begin
					next_prdata = default_addr;
				end
				`VIU_OFF_EVT: begin
					next_prdata = {30'h0, evt_status};
				end
				`VIU_OFF_EVT_MASK: begin
					next_prdata = {30'h0, evt_mask};
				end
				default: begin
					next_slverr = 1'b1;
				end
			endcase
		end
	end

	// global configuration registers
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			src_enable   <= `VIU_RST_WORD;
			class_fast   <= `VIU_RST_WORD;
			default_addr <= `VIU_RST_WORD;
			evt_mask     <= `VIU_RST_EVT;
		end else if (done_wr && !in_slot_ctrl && !in_slot_addr) begin
			case (addr)
				`VIU_OFF_SRC_EN: begin
					src_enable <= merge_strb(src_enable, I_PWDATA, I_PSTRB);
				end
				`VIU_OFF_CLASS: begin
					class_fast <= merge_strb(class_fast, I_PWDATA, I_PSTRB);
				end
				`VIU_OFF_DEFAULT: begin
					default_addr <= merge_strb(default_addr, I_PWDATA, I_PSTRB);
				end
				`VIU_OFF_EVT_MASK: begin
					evt_mask <= I_PSTRB[0] ? I_PWDATA[`VIU_EVT_W-1:0] : evt_mask;
				end
				default: begin
					src_enable <= src_enable;
				end
			endcase
		end
	end

	// slot rewrites apply to the next cycle's pick
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			for (int n = 0; n < `VIU_NUM_SLOTS; n++) begin
				slot_ctrl[n] <= `VIU_RST_CTRL;
				slot_addr[n] <= `VIU_RST_WORD;
			end
		end else if (done_wr && in_slot_ctrl && I_PSTRB[0]) begin
			slot_ctrl[slot_sel] <= I_PWDATA[`VIU_SLOT_CTRL_W-1:0];
		end else if (done_wr && in_slot_addr) begin
			slot_addr[slot_sel] <= merge_strb(slot_addr[slot_sel], I_PWDATA, I_PSTRB);
		end
	end

	// sticky events: only bits already returned are cleared, and a new set wins
	always_comb begin
		next_evt = evt_status;
		if (done_rd && !in_slot_ctrl && !in_slot_addr && addr == `VIU_OFF_EVT) begin
			next_evt = evt_status & ~O_PRDATA[`VIU_EVT_W-1:0];
		end
		if (next_fast && !O_FAST_INTERRUPT_REQUEST) begin
			next_evt[`VIU_EVT_FAST] = 1'b1;
		end
		if (next_normal && !O_NORMAL_INTERRUPT_REQUEST) begin
			next_evt[`VIU_EVT_NORMAL] = 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			evt_status <= `VIU_RST_EVT;
			O_INT      <= 1'b0;
		end else begin
			evt_status <= next_evt;
			O_INT      <= |(next_evt & evt_mask);
		end
	end
endmodule
`default_nettype wire

// [dv/viu_periph_model.sv]
// peripheral side: each request line is the OR of two peripheral flags
`timescale 1ns/1ns
`default_nettype none
module viu_periph_model (
	input  wire logic [63:0]        i_flags,
	output var  viu_pkg::viu_word_t o_req
);
	import viu_pkg::*;
	always_comb begin
		for (int k = 0; k < 32; k++) begin
			o_req[k] = i_flags[2*k] | i_flags[2*k+1];
		end
	end
endmodule
`default_nettype wire

// [dv/viu_ctrl_sva.sv]
// protocol and interrupt checks on the unit's ports
`timescale 1ns/1ns
`default_nettype none
module viu_ctrl_sva (
	input wire logic               I_CLK,
	input wire logic               I_SYS_RST,
	input wire viu_pkg::viu_word_t I_IRQ_SRC,
	input wire logic               I_PSEL,
	input wire logic               I_PENABLE,
	input wire viu_pkg::viu_word_t O_PRDATA,
	input wire logic               O_PREADY,
	input wire logic               O_PSLVERR,
	input wire logic               O_FAST_INTERRUPT_REQUEST,
	input wire logic               O_NORMAL_INTERRUPT_REQUEST,
	input wire logic               O_INT
);
	import viu_pkg::*;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);
	sequence s_setup; I_PSEL && !I_PENABLE; endsequence
	sequence s_access; I_PSEL && I_PENABLE; endsequence
	a_ready_wait: assert property (s_setup ##1 s_access |=> O_PREADY) else $error("no ready after one wait");
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
	a_ready_idle: assert property (!I_PSEL |=> !O_PREADY) else $error("ready without select");
	a_err_ready: assert property (O_PSLVERR |-> O_PREADY) else $error("error without ready");
	a_data_idle: assert property (!O_PREADY |-> O_PRDATA == '0) else $error("read data outside access");
	a_quiet_src: assert property (I_IRQ_SRC == '0 |=> !O_FAST_INTERRUPT_REQUEST && !O_NORMAL_INTERRUPT_REQUEST)
		else $error("request with no source");
	a_fast_cause: assert property ($rose(O_FAST_INTERRUPT_REQUEST) |-> $past(I_IRQ_SRC) != '0)
		else $error("fast request without source");
	a_norm_cause: assert property ($rose(O_NORMAL_INTERRUPT_REQUEST) |-> $past(I_IRQ_SRC) != '0)
		else $error("normal request without source");
	a_reset_quiet: assert property (disable iff (1'b0) I_SYS_RST |=> !O_INT && !O_PREADY)
		else $error("outputs active after reset");
endmodule
bind viu_ctrl viu_ctrl_sva i_sva (.I_CLK, .I_SYS_RST, .I_IRQ_SRC, .I_PSEL, .I_PENABLE, .O_PRDATA, .O_PREADY,
	.O_PSLVERR, .O_FAST_INTERRUPT_REQUEST, .O_NORMAL_INTERRUPT_REQUEST, .O_INT);
`default_nettype wire

// [dv/tb.sv]
// self-checking testbench of the vector interrupt unit
`timescale 1ns/1ns
`default_nettype none
`include "viu_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb;
	import viu_pkg::*;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
	viu_word_t   paddr = '0, pwdata = '0, prdata, src;
	logic [63:0] flags = '0;
	logic        pready, pslverr, fast_interrupt_request, irq, oint;
	int          err_count = 0, checks_done = 0;
	always #20 clk = ~clk;
	viu_periph_model i_pm (.i_flags(flags), .o_req(src));
	viu_ctrl i_dut (.I_CLK(clk), .I_SYS_RST(rst), .I_IRQ_SRC(src), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .O_FAST_INTERRUPT_REQUEST(fast_interrupt_request),
		.O_NORMAL_INTERRUPT_REQUEST(irq), .O_INT(oint));
	task automatic xfer(input logic w, input logic [11:0] a, input viu_word_t d, output viu_word_t r,
		output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= {20'h00000, a};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// no cycle count assumed: only the watchdog ends a stuck wait
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input viu_word_t d);
		viu_word_t r;
		logic e;
		xfer(1'b1, a, d, r, e);
	endtask
	task automatic rd(input logic [11:0] a, input viu_word_t x, input logic xe);
		viu_word_t r;
		logic e;
		xfer(1'b0, a, 32'h0, r, e);
		`CHK("prdata", x, r)
		`CHK("pslverr", xe, e)
	endtask
	task automatic wt();
		repeat (3) @(posedge clk);
	endtask
	task automatic finish_test();
		if (err_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge clk);
		err_count++;
		finish_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(`VIU_OFF_SRC_EN, '0, 1'b0);
		rd(`VIU_OFF_DEFAULT, '0, 1'b0);
		wr(`VIU_OFF_SRC_EN, 32'hFFFF_FDFF);
		wr(`VIU_OFF_CLASS, 32'h0000_0008);
		wr(12'h100, 32'h0000_0025);
		wr(12'h200, 32'h0000_00A0);
		wr(12'h13C, 32'h0000_0026);
		wr(12'h23C, 32'h0000_00F0);
		wr(`VIU_OFF_DEFAULT, 32'h0000_00D0);
		wr(`VIU_OFF_EVT_MASK, 32'h0000_0003);
		// a disabled source must stay invisible
		flags <= 64'h0000_0000_0004_0000;
		wt();
		`CHK("irq", 1'b0, irq)
		rd(`VIU_OFF_VECT, 32'h0000_00D0, 1'b0);
		flags <= 64'h0000_0000_0000_0080;
		wt();
		`CHK("fiq", 1'b1, fast_interrupt_request)
		rd(`VIU_OFF_FAST, 32'h0000_0008, 1'b0);
		rd(`VIU_OFF_EVT, 32'h0000_0001, 1'b0);
		flags <= 64'h0000_0000_0000_1080;
		wt();
		`CHK("irq", 1'b1, irq)
		`CHK("int", 1'b1, oint)
		rd(`VIU_OFF_VECT, 32'h0000_00F0, 1'b0);
		flags <= 64'h0000_0000_0000_1880;
		wt();
		rd(`VIU_OFF_VECT, 32'h0000_00A0, 1'b0);
		rd(`VIU_OFF_NORMAL, 32'h0000_0060, 1'b0);
		rd(`VIU_OFF_RAW, 32'h0000_0068, 1'b0);
		rd(`VIU_OFF_EVT, 32'h0000_0002, 1'b0);
		wt();
		`CHK("int", 1'b0, oint)
		wr(12'h100, 32'h0000_0005);
		rd(`VIU_OFF_VECT, 32'h0000_00F0, 1'b0);
		wr(`VIU_OFF_CLASS, 32'h0000_0048);
		rd(`VIU_OFF_VECT, 32'h0000_00D0, 1'b0);
		// two fast sources at once still give one merged request
		rd(`VIU_OFF_FAST, 32'h0000_0048, 1'b0);
		`CHK("fiq", 1'b1, fast_interrupt_request)
		flags <= 64'h0000_0000_0000_4000;
		wr(`VIU_OFF_CLASS, 32'h0000_0000);
		wt();
		`CHK("fiq", 1'b0, fast_interrupt_request)
		`CHK("irq", 1'b1, irq)
		rd(`VIU_OFF_VECT, 32'h0000_00D0, 1'b0);
		rd(12'h800, '0, 1'b1);
		finish_test();
	end
endmodule
`default_nettype wire
